// ==== shared/csf_params.svh ====
// constants of the status-flag datapath: bit positions, reset values, stack layout, arithmetic limits
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define CSF_BIT_C      0
`define CSF_BIT_Z      1
`define CSF_BIT_I      2
`define CSF_BIT_D      3
`define CSF_BIT_B      4
`define CSF_BIT_T      5
`define CSF_BIT_V      6
`define CSF_BIT_N      7

// ----------------------------------------------------------------
// reset values, stack layout and arithmetic limits
// ----------------------------------------------------------------
`define CSF_STATUS_RST 8'h04
`define CSF_SP_RST     8'hFF
`define CSF_STACK_PAGE 8'h01
`define CSF_DIV0_QUOT  8'hFF
`define CSF_BCD_MAX    8'h09
`define CSF_DEC_LIMIT  8'd99

`endif

// ==== shared/csf_pkg.sv ====
// types of the status-flag datapath
package csf_pkg;

   // ----------------------------------------------------------------
   // operations accepted by the core
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP, OP_ADC, OP_SUB, OP_AND, OP_XOR, OP_OR,
      OP_BCLR, OP_BSET, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_NIB,
      OP_DECR, OP_INC, OP_COM,
      OP_SETC, OP_CLRC, OP_SETD, OP_CLRD, OP_SET, OP_CLT,
      OP_PUSH, OP_PULL, OP_MULT, OP_DIV
   } csf_op_e;

   typedef enum logic [1:0] {
      ST_IDLE, ST_RD, ST_WAIT
   } csf_state_e;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       v;
      logic       c_upd;
      logic       v_upd;
      logic       nz_upd;
   } csf_alu_s;

endpackage : csf_pkg

// ==== logic/csf_core.sv ====
// status word, decimal arithmetic and read-modify-write sequencing of the core
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "csf_params.svh"

module csf_core
   import csf_pkg::*;
(
   input  wire logic        clk_sys,     // 20 MHz core clock
   input  wire logic        rstn,        // synchronous reset, active low
   input  wire logic        op_start,    // request to execute op_sel
   input  csf_op_e          op_sel,      // operation to execute
   input  wire logic [15:0] op_addr,     // memory address for memory operations
   input  wire logic [7:0]  op_operand,  // second operand byte
   input  wire logic [7:0]  op_ext,      // upper dividend byte for divide
   input  wire logic [2:0]  op_bit,      // bit index for bit clear and set
   input  wire logic [7:0]  mem_rdata,   // read data, valid the cycle after mem_rd
   output logic             op_busy,     // core cannot take a request
   output logic             op_done,     // operation finished
   output logic [7:0]       acc,         // accumulator
   output logic [7:0]       res_hi,      // product high byte or remainder
   output logic [7:0]       status_word, // processor status word
   output logic [7:0]       stack_ptr,   // stack pointer
   output logic             mem_rd,      // memory read strobe
   output logic             mem_wr,      // memory write strobe
   output logic [15:0]      mem_addr,    // memory address
   output logic [7:0]       mem_wdata    // memory write data
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   csf_state_e  state_ff;
   csf_op_e     cur_op_ff;
   logic [7:0]  operand_ff;
   logic [2:0]  bit_ff;
   logic [7:0]  status_ff;
   logic [7:0]  acc_ff;
   logic [7:0]  res_hi_ff;
   logic [7:0]  sp_ff;
   logic        done_ff;
   logic        mem_rd_ff;
   logic        mem_wr_ff;
   logic [15:0] mem_addr_ff;
   logic [7:0]  mem_wdata_ff;
   logic        accept;
   logic        start_rmw;
   csf_alu_s    acc_alu;
   csf_alu_s    mem_alu;
   logic [15:0] product;
   logic [15:0] dividend;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // fixed read-modify-write class
   function automatic logic is_rmw_fixed(csf_op_e op);
      is_rmw_fixed = (op == OP_BCLR) || (op == OP_BSET) || (op == OP_SHL) ||
                     (op == OP_SHR) || (op == OP_ROTL) || (op == OP_ROTR) ||
                     (op == OP_NIB) || (op == OP_DECR) || (op == OP_INC) ||
                     (op == OP_COM);
   endfunction : is_rmw_fixed

   // ops that become read-modify-write in index-memory mode
   function automatic logic is_tmode_op(csf_op_e op);
      is_tmode_op = (op == OP_ADC) || (op == OP_SUB) || (op == OP_AND) ||
                    (op == OP_XOR) || (op == OP_OR);
   endfunction : is_tmode_op

   function automatic csf_alu_s alu_eval(csf_op_e op, logic [7:0] a, logic [7:0] b,
                                         logic cin, logic dmode, logic [2:0] bi);
      csf_alu_s   r;
      logic [8:0] s9;
      logic [7:0] bb;
      logic [4:0] lo;
      logic [4:0] hi;
      logic [5:0] dl;
      logic [5:0] dh;
      logic       bor;
      r.res    = a;
      r.c      = cin;
      r.v      = 1'b0;
      r.c_upd  = 1'b0;
      r.v_upd  = 1'b0;
      r.nz_upd = 1'b1;
      bb       = (op == OP_SUB) ? ~b : b;
      s9       = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
      lo       = 5'h00;
      hi       = 5'h00;
      dl       = 6'h00;
      dh       = 6'h00;
      bor      = 1'b0;
      case (op)
         OP_ADC, OP_SUB: begin
            r.c_upd = 1'b1;
            if (!dmode) begin
               r.res   = s9[7:0];
               r.c     = s9[8];
               r.v     = (a[7] == bb[7]) && (s9[7] != a[7]);
               r.v_upd = 1'b1;
            end else if (op == OP_ADC) begin
               lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
               if (lo > 5'd9) begin
                  lo = lo + 5'd6;
               end
               hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
               if (hi > 5'd9) begin
                  hi = hi + 5'd6;
               end
               r.res    = {hi[3:0], lo[3:0]};
               r.c      = hi[4];
               r.nz_upd = 1'b0;
            end else begin
               dl = {2'b00, a[3:0]} - {2'b00, b[3:0]} - {5'h00, ~cin};
               if (dl[5]) begin
                  dl  = dl - 6'd6;
                  bor = 1'b1;
               end
               dh = {2'b00, a[7:4]} - {2'b00, b[7:4]} - {5'h00, bor};
               r.c = ~dh[5];
               if (dh[5]) begin
                  dh = dh - 6'd6;
               end
               r.res    = {dh[3:0], dl[3:0]};
               r.nz_upd = 1'b0;
            end
         end
         OP_AND: r.res = a & b;
         OP_XOR: r.res = a ^ b;
         OP_OR:  r.res = a | b;
         OP_BCLR: begin
            r.res    = a & ~(8'h01 << bi);
            r.nz_upd = 1'b0;
         end
         OP_BSET: begin
            r.res    = a | (8'h01 << bi);
            r.nz_upd = 1'b0;
         end
         OP_SHL: begin
            r.res   = {a[6:0], 1'b0};
            r.c     = a[7];
            r.c_upd = 1'b1;
         end
         OP_SHR: begin
            r.res   = {1'b0, a[7:1]};
            r.c     = a[0];
            r.c_upd = 1'b1;
         end
         OP_ROTL: begin
            r.res   = {a[6:0], cin};
            r.c     = a[7];
            r.c_upd = 1'b1;
         end
         OP_ROTR: begin
            r.res   = {cin, a[7:1]};
            r.c     = a[0];
            r.c_upd = 1'b1;
         end
         OP_NIB: begin
            r.res    = {a[3:0], a[7:4]};
            r.nz_upd = 1'b0;
         end
         OP_DECR: r.res = a - 8'h01;
         OP_INC: r.res = a + 8'h01;
         OP_COM: r.res = ~a;
         default: r.nz_upd = 1'b0;
      endcase
      alu_eval = r;
   endfunction : alu_eval

   // fold an alu result into the status word
   function automatic logic [7:0] fold_flags(logic [7:0] st, csf_alu_s r);
      logic [7:0] s;
      s = st;
      if (r.c_upd) begin
         s[`CSF_BIT_C] = r.c;
      end
      if (r.v_upd) begin
         s[`CSF_BIT_V] = r.v;
      end
      if (r.nz_upd) begin
         s[`CSF_BIT_Z] = (r.res == 8'h00);
         s[`CSF_BIT_N] = r.res[7];
      end
      fold_flags = s;
   endfunction : fold_flags

   // ----------------------------------------------------------------
   // decode and datapath
   // ----------------------------------------------------------------
   assign accept    = op_start && (state_ff == ST_IDLE);
   assign start_rmw = is_rmw_fixed(op_sel) ||
                      (is_tmode_op(op_sel) && status_ff[`CSF_BIT_T]);
   assign acc_alu   = alu_eval(op_sel, acc_ff, op_operand, status_ff[`CSF_BIT_C],
                               status_ff[`CSF_BIT_D], op_bit);
   assign mem_alu   = alu_eval(cur_op_ff, mem_rdata, operand_ff, status_ff[`CSF_BIT_C],
                               status_ff[`CSF_BIT_D], bit_ff);
   // multiply and divide read neither mode flag
   assign product   = acc_ff * op_operand;
   assign dividend  = {op_ext, acc_ff};

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_ff   <= ST_IDLE;
         cur_op_ff  <= OP_NOP;
         operand_ff <= 8'h00;
         bit_ff     <= 3'h0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (accept && (start_rmw || (op_sel == OP_PULL))) begin
                  state_ff   <= ST_RD;
                  cur_op_ff  <= op_sel;
                  operand_ff <= op_operand;
                  bit_ff     <= op_bit;
               end
            end
            ST_RD:   state_ff <= ST_WAIT;
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // memory strobes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         mem_rd_ff    <= 1'b0;
         mem_wr_ff    <= 1'b0;
         mem_addr_ff  <= 16'h0000;
         mem_wdata_ff <= 8'h00;
      end else begin
         mem_rd_ff <= 1'b0;
         mem_wr_ff <= 1'b0;
         if (accept && start_rmw) begin
            mem_rd_ff   <= 1'b1;
            mem_addr_ff <= op_addr;
         end else if (accept && (op_sel == OP_PUSH)) begin
            mem_wr_ff    <= 1'b1;
            mem_addr_ff  <= {`CSF_STACK_PAGE, sp_ff};
            mem_wdata_ff <= status_ff;
         end else if (accept && (op_sel == OP_PULL)) begin
            mem_rd_ff   <= 1'b1;
            mem_addr_ff <= {`CSF_STACK_PAGE, sp_ff + 8'h01};
         end else if ((state_ff == ST_WAIT) && (cur_op_ff != OP_PULL)) begin
            mem_wr_ff    <= 1'b1;
            mem_wdata_ff <= mem_alu.res;
         end
      end
   end

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         status_ff <= `CSF_STATUS_RST;
      end else if (state_ff == ST_WAIT) begin
         if (cur_op_ff == OP_PULL) begin
            status_ff <= mem_rdata;
         end else begin
            status_ff <= fold_flags(status_ff, mem_alu);
         end
      end else if (accept && !start_rmw) begin
         case (op_sel)
            OP_SETC:        status_ff[`CSF_BIT_C] <= 1'b1;
            OP_CLRC:        status_ff[`CSF_BIT_C] <= 1'b0;
            OP_SETD:        status_ff[`CSF_BIT_D] <= 1'b1;
            OP_CLRD:        status_ff[`CSF_BIT_D] <= 1'b0;
            OP_SET:         status_ff[`CSF_BIT_T] <= 1'b1;
            OP_CLT:         status_ff[`CSF_BIT_T] <= 1'b0;
            OP_ADC, OP_SUB,
            OP_AND, OP_XOR,
            OP_OR:          status_ff <= fold_flags(status_ff, acc_alu);
            default:        status_ff <= status_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // accumulator, result high byte, stack pointer, done
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         acc_ff    <= 8'h00;
         res_hi_ff <= 8'h00;
      end else if (accept && !start_rmw) begin
         if (is_tmode_op(op_sel)) begin
            acc_ff <= acc_alu.res;
         end else if (op_sel == OP_MULT) begin
            acc_ff    <= product[7:0];
            res_hi_ff <= product[15:8];
         end else if (op_sel == OP_DIV) begin
            if (op_operand == 8'h00) begin
               acc_ff    <= `CSF_DIV0_QUOT;
               res_hi_ff <= op_ext;
            end else begin
               acc_ff    <= 8'(dividend / {8'h00, op_operand});
               res_hi_ff <= 8'(dividend % {8'h00, op_operand});
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sp_ff <= `CSF_SP_RST;
      end else if (accept && (op_sel == OP_PUSH)) begin
         sp_ff <= sp_ff - 8'h01;
      end else if (accept && (op_sel == OP_PULL)) begin
         sp_ff <= sp_ff + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= (state_ff == ST_WAIT) ||
                    (accept && !start_rmw && (op_sel != OP_PULL));
      end
   end

   assign op_busy     = (state_ff != ST_IDLE);
   assign op_done     = done_ff;
   assign acc         = acc_ff;
   assign res_hi      = res_hi_ff;
   assign status_word = status_ff;
   assign stack_ptr   = sp_ff;
   assign mem_rd      = mem_rd_ff;
   assign mem_wr      = mem_wr_ff;
   assign mem_addr    = mem_addr_ff;
   assign mem_wdata   = mem_wdata_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   function automatic logic [7:0] bcd_val(logic [7:0] x);
      bcd_val = 8'({4'h0, x[7:4]} * 8'd10 + {4'h0, x[3:0]});
   endfunction : bcd_val

   function automatic logic bcd_ok(logic [7:0] x);
      bcd_ok = ({4'h0, x[7:4]} <= `CSF_BCD_MAX) && ({4'h0, x[3:0]} <= `CSF_BCD_MAX);
   endfunction : bcd_ok

   reset_imask_a: assert property (@(posedge clk_sys)
      $rose(rstn) |-> status_ff[`CSF_BIT_I] && op_done == 1'b0)
      else $error("interrupt mask not set after reset");

   push_stack_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept && op_sel == OP_PUSH |=> mem_wr_ff && mem_wdata_ff == $past(status_ff) &&
      mem_addr_ff == {`CSF_STACK_PAGE, sp_ff + 8'h01})
      else $error("status push not readable at stack pointer plus one");

   pull_restore_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept && op_sel == OP_PULL |=> ##1 1'b1 ##1 status_ff == $past(mem_rdata) && op_done)
      else $error("status pull did not restore the stack byte");

   dec_carry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept && op_sel == OP_ADC && status_ff[`CSF_BIT_D] && !status_ff[`CSF_BIT_T] &&
      bcd_ok(acc_ff) && bcd_ok(op_operand) |=> status_ff[`CSF_BIT_C] ==
      (9'($past(bcd_val(acc_ff))) + 9'($past(bcd_val(op_operand))) +
       9'($past(status_ff[`CSF_BIT_C])) > 9'(`CSF_DEC_LIMIT)))
      else $error("decimal carry wrong");

   inc_binary_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_ff == ST_WAIT && cur_op_ff == OP_INC |=> mem_wdata_ff == $past(mem_rdata) + 8'h01)
      else $error("increment was decimal adjusted");

   muldiv_flags_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept && (op_sel == OP_MULT || op_sel == OP_DIV) |=> $stable(status_ff) && op_done)
      else $error("multiply or divide changed the status word");

   mul_result_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept && op_sel == OP_MULT |=> !mem_rd_ff &&
      {res_hi_ff, acc_ff} == $past(acc_ff) * $past(op_operand))
      else $error("multiply result depends on mode");

   rmw_same_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      mem_rd_ff && cur_op_ff != OP_PULL |-> ##2 mem_wr_ff && mem_addr_ff == $past(mem_addr_ff, 2))
      else $error("write-back went to another address");

   rmw_class_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept && is_rmw_fixed(op_sel) |=> mem_rd_ff && mem_addr_ff == $past(op_addr))
      else $error("operation did not start a memory read");

   tmode_rmw_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept && is_tmode_op(op_sel) |=> mem_rd_ff == $past(status_ff[`CSF_BIT_T]))
      else $error("index-memory mode selection wrong");

endmodule : csf_core

// ==== dv/csf_mem_model.sv ====
// memory partner of the status-flag core: data and stack
`timescale 1ns/1ps

module csf_mem_model (
   input  wire logic        clk_sys,   // core clock
   input  wire logic        mem_rd,    // read strobe
   input  wire logic        mem_wr,    // write strobe
   input  wire logic [15:0] mem_addr,  // address
   input  wire logic [7:0]  mem_wdata, // write data
   output logic      [7:0]  mem_rdata  // read data, one cycle after the strobe
);
   logic [7:0]  mem [0:511];
   logic [15:0] last_rd;
   logic [15:0] last_wr;

   initial begin
      mem_rdata = 8'h00;
      last_rd   = 16'h0000;
      last_wr   = 16'h0000;
   end

   // ----------------------------------------------------------------
   // read answers one cycle late; between reads the bus inverts every cycle
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (mem_rd) begin
         mem_rdata <= mem[mem_addr[8:0]];
         last_rd   <= mem_addr;
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      // stack bytes land here and stay readable at sp plus one
      if (mem_wr) begin
         mem[mem_addr[8:0]] <= mem_wdata;
         last_wr            <= mem_addr;
      end
   end
endmodule : csf_mem_model

// ==== dv/test_csf_core.sv ====
// self-checking bench of the status-flag core
`timescale 1ns/1ps
`include "csf_params.svh"

module test_csf_core;
   import csf_pkg::*;
   typedef struct {
      csf_op_e    op;
      logic [7:0] opnd, ext, acc, hi, st, msk;
   } csf_row_s;

   logic        clk_sys, rstn, op_start, op_busy, op_done, mem_rd, mem_wr;
   csf_op_e     op_sel;
   logic [15:0] op_addr, mem_addr;
   logic [7:0]  op_operand, op_ext, mem_rdata, acc, res_hi, status_word, stack_ptr, mem_wdata;
   logic [2:0]  op_bit;
   int          err_total, num_checks;
   csf_row_s    rows[29] = '{
   '{OP_CLRD,8'h00,8'h00,8'h00,8'h00,8'h04,8'h2D}, '{OP_CLT,8'h00,8'h00,8'h00,8'h00,8'h04,8'h2D},
   '{OP_CLRC,8'h00,8'h00,8'h00,8'h00,8'h04,8'h2D}, '{OP_ADC,8'h45,8'h00,8'h45,8'h00,8'h04,8'hEF},
   '{OP_SETD,8'h00,8'h00,8'h45,8'h00,8'h0C,8'hEF}, '{OP_CLRC,8'h00,8'h00,8'h45,8'h00,8'h0C,8'hEF},
   '{OP_ADC,8'h38,8'h00,8'h83,8'h00,8'h0C,8'h2D}, '{OP_NOP,8'h00,8'h00,8'h83,8'h00,8'h0C,8'h2D},
   '{OP_ADC,8'h17,8'h00,8'h00,8'h00,8'h0D,8'h2D}, '{OP_NOP,8'h00,8'h00,8'h00,8'h00,8'h0D,8'h2D},
   '{OP_SETC,8'h00,8'h00,8'h00,8'h00,8'h0D,8'h2D}, '{OP_SUB,8'h01,8'h00,8'h99,8'h00,8'h0C,8'h2D},
   '{OP_NOP,8'h00,8'h00,8'h99,8'h00,8'h0C,8'h2D}, '{OP_CLRD,8'h00,8'h00,8'h99,8'h00,8'h04,8'h2D},
   '{OP_CLRC,8'h00,8'h00,8'h99,8'h00,8'h04,8'h2D}, '{OP_ADC,8'h67,8'h00,8'h00,8'h00,8'h07,8'hEF},
   '{OP_ADC,8'h7F,8'h00,8'h80,8'h00,8'hC4,8'hEF}, '{OP_SETD,8'h00,8'h00,8'h80,8'h00,8'hCC,8'hEF},
   '{OP_SET,8'h00,8'h00,8'h80,8'h00,8'hEC,8'hEF}, '{OP_MULT,8'h03,8'h00,8'h80,8'h01,8'hEC,8'hEF},
   '{OP_DIV,8'h07,8'h01,8'h36,8'h06,8'hEC,8'hEF}, '{OP_DIV,8'h00,8'h12,8'hFF,8'h12,8'hEC,8'hEF},
   '{OP_CLT,8'h00,8'h00,8'hFF,8'h12,8'hCC,8'hEF}, '{OP_CLRD,8'h00,8'h00,8'hFF,8'h12,8'hC4,8'hEF},
   '{OP_AND,8'h0F,8'h00,8'h0F,8'h12,8'h44,8'hEF}, '{OP_XOR,8'h0F,8'h00,8'h00,8'h12,8'h46,8'hEF},
   '{OP_OR,8'h81,8'h00,8'h81,8'h12,8'hC4,8'hEF}, '{OP_SETC,8'h00,8'h00,8'h81,8'h12,8'hC5,8'hEF},
   '{OP_SUB,8'h01,8'h00,8'h80,8'h12,8'h85,8'hEF}};
   csf_op_e     rmw_op[10] = '{OP_BCLR, OP_BSET, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_NIB,
                               OP_DECR, OP_INC, OP_COM};
   logic [7:0]  rmw_exp[10] = '{8'h94, 8'h97, 8'h2C, 8'h4B, 8'h2C, 8'h4B, 8'h69,
                                8'h95, 8'h97, 8'h69};
   csf_op_e     tm_op[5] = '{OP_ADC, OP_SUB, OP_AND, OP_XOR, OP_OR};
   logic [7:0]  tm_exp[5] = '{8'hA5, 8'h86, 8'h06, 8'h99, 8'h9F};

   csf_core csf_core_i (.clk_sys(clk_sys), .rstn(rstn), .op_start(op_start), .op_sel(op_sel),
      .op_addr(op_addr), .op_operand(op_operand), .op_ext(op_ext), .op_bit(op_bit),
      .mem_rdata(mem_rdata), .op_busy(op_busy), .op_done(op_done), .acc(acc),
      .res_hi(res_hi), .status_word(status_word), .stack_ptr(stack_ptr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
   csf_mem_model csf_mem_model_i (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic do_op(input csf_op_e op, input logic [7:0] opnd = 8'h00,
                        input logic [2:0] bt = 3'd0, input logic [7:0] ext = 8'h00);
      int n;
      @(negedge clk_sys);
      op_sel     = op;
      op_operand = opnd;
      op_bit     = bt;
      op_ext     = ext;
      op_start   = 1'b1;
      @(negedge clk_sys);
      op_start = 1'b0;
      n = 0;
      chk("op_busy", 16'(op_busy), 16'(!op_done));
      while (op_done !== 1'b1 && n < 8) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 8) chk("op_done", 16'h0000, 16'h0001);
      // the closing memory write lands at the edge after op_done
      @(negedge clk_sys);
   endtask : do_op

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      #(2000 * 50);
      err_total++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      err_total = 0;
      num_checks = 0;
      rstn = 1'b0;
      op_start = 1'b0;
      op_sel = OP_NOP;
      op_addr = 16'h0040;
      op_operand = 8'h00;
      op_ext = 8'h00;
      op_bit = 3'd0;
      repeat (4) @(negedge clk_sys);
      rstn = 1'b1;
      chk("irq mask", 16'(status_word[`CSF_BIT_I]), 16'h0001);
      chk("sp", 16'(stack_ptr), 16'h00FF);
      $display("test reset done");
      // software clears index and decimal modes first
      // no indirect jump is issued, so no pointer sits at a page end
      foreach (rows[i]) begin
         do_op(rows[i].op, rows[i].opnd, 3'd0, rows[i].ext);
         chk("acc", 16'(acc), 16'(rows[i].acc));
         chk("res_hi", 16'(res_hi), 16'(rows[i].hi));
         chk("status", 16'(status_word & rows[i].msk), 16'(rows[i].st & rows[i].msk));
         if (rows[i].op == OP_MULT || rows[i].op == OP_DIV)
            chk("status muldiv", 16'(status_word), 16'h00EC);
      end
      $display("test table done");
      do_op(OP_PUSH);
      chk("pushed", 16'(csf_mem_model_i.mem[9'h1FF]), 16'h0085);
      chk("sp push", 16'(stack_ptr), 16'h00FE);
      csf_mem_model_i.mem[9'h1FF] = 8'h43;
      do_op(OP_PULL);
      chk("pulled", 16'(status_word), 16'h0043);
      chk("sp pull", 16'(stack_ptr), 16'h00FF);
      $display("test stack done");
      // target is ordinary data memory, never an unreadable register
      // decimal mode on: these ops must still act in binary
      do_op(OP_SETD);
      foreach (rmw_op[i]) begin
         do_op(OP_CLRC);
         csf_mem_model_i.mem[9'h040] = 8'h96;
         do_op(rmw_op[i], 8'h00, (i == 0) ? 3'd1 : 3'd0);
         chk("rmw data", 16'(csf_mem_model_i.mem[9'h040]), 16'(rmw_exp[i]));
         chk("rmw addr", csf_mem_model_i.last_wr, csf_mem_model_i.last_rd);
         chk("rmw acc", 16'(acc), 16'h0080);
      end
      $display("test rmw done");
      do_op(OP_CLRD);
      do_op(OP_SET);
      foreach (tm_op[i]) begin
         do_op(OP_CLRC);
         csf_mem_model_i.mem[9'h040] = 8'h96;
         csf_mem_model_i.last_wr = 16'h0000;
         do_op(tm_op[i], 8'h0F);
         chk("tmode data", 16'(csf_mem_model_i.mem[9'h040]), 16'(tm_exp[i]));
         chk("tmode addr", csf_mem_model_i.last_wr, 16'h0040);
         chk("tmode acc", 16'(acc), 16'h0080);
      end
      do_op(OP_CLT);
      $display("test index mode done");
      @(negedge clk_sys);
      rstn = 1'b0;
      repeat (4) @(negedge clk_sys);
      rstn = 1'b1;
      chk("irq mask again", 16'(status_word[`CSF_BIT_I]), 16'h0001);
      $display("test second reset done");
      end_sim();
   end
endmodule : test_csf_core
